// [design/sacs_params.svh]
// Timing counts and widths shared by the converter sequencer and its host.
// Assumes a 50 MHz system clock on both ends.
`ifndef SACS_PARAMS_SVH
`define SACS_PARAMS_SVH
`define SACS_CLK_MHZ          50
`define SACS_RES_BITS         14
`define SACS_ACC_BITS         24
`define SACS_CAL_CYCLES       64
`define SACS_CONV_NS          600
`define SACS_CONV_CYCLES      ((`SACS_CONV_NS * `SACS_CLK_MHZ + 999) / 1000)
`define SACS_QUIET_NS         10
`define SACS_QUIET_CYCLES     (((`SACS_QUIET_NS * `SACS_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
                               ((`SACS_QUIET_NS * `SACS_CLK_MHZ + 999) / 1000))
`define SACS_SCLK_DIV         4
`define SACS_ACQ_EXTRA        8
`endif

// [design/sacs_pkg.sv]
// Types shared by the converter sequencer and its host.
// Assumes the parameter header is included where counts are needed.
package sacs_pkg;
    typedef enum {SACS_CAL, SACS_ACQ, SACS_CONV, SACS_WAITLOW} sacs_dev_e;
    typedef enum {SACS_H_IDLE, SACS_H_CONV, SACS_H_SHIFT, SACS_H_QUIET} sacs_host_e;
endpackage : sacs_pkg

// [design/sacs_link_if.sv]
// Serial link between the converter sequencer and the host.
// Assumes the host drives start and serial clock; the device drives data out.
interface sacs_link_if;
    logic convStart;
    logic serialClk;
    logic serialData;
    logic serialDataEn;
    modport device (input convStart, input serialClk, output serialData, output serialDataEn);
    modport host   (output convStart, output serialClk, input serialData, input serialDataEn);
endinterface : sacs_link_if

// [design/sacs_device.sv]
// Device end: calibration, acquisition, conversion and serial readout of a SAR converter.
// Assumes link pins come from outside the clock domain and are synchronised here.
// Assumes the sample word is already saturated to the code range by the front end.
// Assumes the host holds the serial clock low while a conversion runs.
// Assumes the accumulated sum fits the accumulator width; wider sums are not modelled.
//
// Summary of operation
// R1 - Calibrate at power-up, then acquire automatically.
// R2 - Track input until conversion-start rising edge.
// R3 - Host sets acquisition length freely.
// R4 - Start rising edge freezes sample, starts conversion.
// R5 - Conversion always runs to completion.
// R6 - Conversion duration is fixed internally.
// R7 - Output only after conversion and start low.
// R8 - Result shifted out most significant bit first.
// R9 - Acquisition resumes while result shifts out.
// R10 - Host leaves quiet time before next start.
// R11 - Host minimises activity during conversion.
// R12 - Sample rate is one over acquisition plus conversion.
// R13 - Host shifts all bits within acquisition time.
// R14 - One code step weighs two reference over two-to-N.
// R15 - Result coded in two's complement, sign first.
// R16 - Result saturates at full-scale codes; an accumulated sum is cut to its low bits on the wire instead.
// R17 - Serial clock pulse discards result, else accumulate.
// R18 - One bit per serial clock, then stop.
`include "sacs_params.svh"
module sacs_device
    import sacs_pkg::*;
#(
    parameter int RES_BITS  = `SACS_RES_BITS,
    parameter int ACC_BITS  = `SACS_ACC_BITS,
    parameter int CONV_CYC  = `SACS_CONV_CYCLES,
    parameter int CAL_CYC   = `SACS_CAL_CYCLES
)(
    input  wire logic                clk,
    input  wire logic                srst,
    sacs_link_if.device              link,
    input  wire logic signed [RES_BITS-1:0] sampleIn,
    output logic                     tracking,
    output logic                     converting,
    output logic                     calibrating
);
    // Phase, synchroniser stages and the result path.
    sacs_dev_e                state_r;
    logic [2:0]               startSync_r;
    logic [2:0]               clkSync_r;
    logic [15:0]              cnt_r;
    logic signed [RES_BITS-1:0] held_r;
    logic signed [ACC_BITS-1:0] acc_r;
    logic [ACC_BITS-1:0]      shift_r;
    logic [5:0]               bitsLeft_r;
    logic                     drive_r;
    logic                     discard_r;
    logic                     accValid_r;

    // Rising edge of a synchronised pin, judged on the second and third stages.
    // The first stage may still be settling, so it is never read here.
    function automatic logic riseOf(input logic [2:0] s);
        return s[1] & ~s[2];
    endfunction : riseOf

    // Falling counterpart of the edge test above.
    function automatic logic fallOf(input logic [2:0] s);
        return ~s[1] & s[2];
    endfunction : fallOf

    // Edge and level decodes of the host pins and the conversion end.
    wire startRise = riseOf(startSync_r); // R2 R4
    wire startLow  = ~startSync_r[1]; // R7
    wire sclkFall  = fallOf(clkSync_r); // R18
    wire sclkRise  = riseOf(clkSync_r); // R17
    wire convDone  = (cnt_r == 16'(CONV_CYC - 1)); // R6
    // Accumulated sum of a fresh result, or the result alone after a discard.
    wire signed [ACC_BITS-1:0] sampleExt = ACC_BITS'(held_r);
    wire signed [ACC_BITS-1:0] sumNext = (accValid_r && !discard_r) ? acc_r + sampleExt : sampleExt; // R17

    // Synchronisers for the two host pins. Both pins come from outside this
    // clock domain, so each passes two flops before any decode reads it.
    // Reset clears them to the idle low level, so no false edge follows reset.
    always_ff @(posedge clk)
    begin
        startSync_r <= srst ? 3'h0 : {startSync_r[1:0], link.convStart};
        clkSync_r   <= srst ? 3'h0 : {clkSync_r[1:0], link.serialClk};
    end

    // Phase sequencer: calibration, acquisition, conversion, then a wait for
    // the start pin to fall. Start edges seen outside acquisition are ignored,
    // so a conversion can neither be aborted nor restarted once it runs.
    // The conversion length is a fixed count that the host cannot change.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= SACS_CAL;
            cnt_r   <= 16'h0;
        end
        else
        begin
            case (state_r)
                // Calibration runs once after reset with no host command.
                SACS_CAL:
                begin
                    cnt_r <= cnt_r + 16'h1;
                    if (cnt_r == 16'(CAL_CYC - 1))
                    begin
                        state_r <= SACS_ACQ; // R1
                        cnt_r   <= 16'h0;
                    end
                end
                // Acquisition lasts until the host raises the start pin.
                SACS_ACQ:
                begin
                    if (startRise)
                        state_r <= SACS_CONV; // R2 R4
                end
                // Conversion counts out its fixed length and then waits.
                SACS_CONV:
                begin
                    cnt_r <= cnt_r + 16'h1; // R5 R6
                    if (convDone)
                    begin
                        state_r <= SACS_WAITLOW;
                        cnt_r   <= 16'h0;
                    end
                end
                // Readout begins and acquisition resumes once start is low.
                SACS_WAITLOW:
                begin
                    if (startLow)
                        state_r <= SACS_ACQ; // R7 R9
                end
                // An illegal phase falls back to a fresh calibration.
                default:
                    state_r <= SACS_CAL;
            endcase
        end
    end

    // Sample hold: tracks during acquisition, frozen from the start edge on.
    // The word seen in the start-edge cycle is not taken, which keeps the frozen value clean.
    always_ff @(posedge clk)
    begin
        if (srst)
            held_r <= '0;
        else if (state_r == SACS_ACQ && !startRise)
            held_r <= sampleIn; // R2 R14 R15 R16
    end

    // Result store, accumulation and discard tracking. A serial clock pulse
    // after a result exists marks it for discard, so the next conversion
    // replaces it; with no pulse the next conversion is added to it. A pulse
    // in the very cycle a result lands still counts against that result.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            acc_r      <= '0;
            accValid_r <= 1'b0;
            discard_r  <= 1'b0;
        end
        else if (state_r == SACS_CONV && convDone)
        begin
            acc_r      <= sumNext; // R17
            accValid_r <= 1'b1;
            discard_r  <= sclkRise; // R17
        end
        else if (sclkRise && accValid_r)
            discard_r <= 1'b1; // R17
    end

    // Serial shifter: loads after start low, one bit per serial clock falling edge.
    // The first bit stands on the pin before the host's first rising edge, and
    // the enable drops after the last bit or when the next conversion starts.
    // Only the low result-width bits of the store are shifted, so an accumulated
    // sum larger than one result is cut to its low bits on the wire.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            shift_r    <= '0;
            bitsLeft_r <= 6'h0;
            drive_r    <= 1'b0;
        end
        else if (state_r == SACS_WAITLOW && startLow)
        begin
            shift_r    <= acc_r << (ACC_BITS - RES_BITS); // R7 R8
            bitsLeft_r <= 6'(RES_BITS);
            drive_r    <= 1'b1;
        end
        else if (state_r == SACS_CONV)
            drive_r <= 1'b0;
        else if (sclkFall && drive_r)
        begin
            shift_r    <= {shift_r[ACC_BITS-2:0], 1'b0}; // R8 R18
            bitsLeft_r <= bitsLeft_r - 6'h1;
            if (bitsLeft_r == 6'h1)
                drive_r <= 1'b0; // R18
        end
    end

    // Pin drivers and phase flags. The data pin shows the shifter's top bit,
    // which rests low once every bit has gone out, and the flags decode the
    // phase register directly.
    assign link.serialData   = shift_r[ACC_BITS-1];
    assign link.serialDataEn = drive_r;
    assign tracking          = (state_r == SACS_ACQ);
    assign converting        = (state_r == SACS_CONV);
    assign calibrating       = (state_r == SACS_CAL);
endmodule : sacs_device

// [design/sacs_host.sv]
// Host end: paces conversion starts and clocks the result out of the device.
// Assumes the data pin comes from outside the clock domain.
`include "sacs_params.svh"
module sacs_host
    import sacs_pkg::*;
#(
    parameter int RES_BITS  = `SACS_RES_BITS,
    parameter int CONV_CYC  = `SACS_CONV_CYCLES,
    parameter int DIV       = `SACS_SCLK_DIV,
    parameter int QUIET_CYC = `SACS_QUIET_CYCLES
)(
    input  wire logic                clk,
    input  wire logic                srst,
    sacs_link_if.host                link,
    input  wire logic                startReq,
    output logic                     busy,
    output logic [RES_BITS-1:0]      result,
    output logic                     resultValid
);
    sacs_host_e           state_r;
    logic [15:0]          cnt_r;
    logic [5:0]           bits_r;
    logic                 sclk_r;
    logic                 start_r;
    logic [1:0]           dataSync_r;
    logic [RES_BITS-1:0]  rx_r;
    logic [RES_BITS-1:0]  result_r;
    logic                 valid_r;

    // Half-period enable from the divider drives the serial clock.
    wire halfTick = (cnt_r == 16'(DIV - 1));
    // Next receive word. Data is taken at the end of the high half: the device
    // shifts only after its synchronisers see the falling edge, and this end's
    // own synchroniser adds two more cycles, so the rising edge comes too early.
    wire [RES_BITS-1:0] rxNext = {rx_r[RES_BITS-2:0], dataSync_r[1]};

    always_ff @(posedge clk)
        dataSync_r <= srst ? 2'h0 : {dataSync_r[0], link.serialData};

    // Start, wait conversion plus synchroniser margin, shift, then quiet gap.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= SACS_H_IDLE;
            cnt_r   <= 16'h0;
            bits_r  <= 6'h0;
            sclk_r  <= 1'b0;
            start_r <= 1'b0;
            rx_r    <= '0;
            result_r <= '0;
            valid_r <= 1'b0;
        end
        else
        begin
            valid_r <= 1'b0;
            case (state_r)
                SACS_H_IDLE:
                begin
                    if (startReq) // R3
                    begin
                        start_r <= 1'b1; // R12
                        cnt_r   <= 16'h0;
                        state_r <= SACS_H_CONV;
                    end
                end
                SACS_H_CONV:
                begin
                    cnt_r <= cnt_r + 16'h1; // R11
                    if (cnt_r == 16'(CONV_CYC + `SACS_ACQ_EXTRA))
                    begin
                        start_r <= 1'b0; // R7
                        cnt_r   <= 16'h0;
                        bits_r  <= 6'(RES_BITS);
                        state_r <= SACS_H_SHIFT;
                    end
                end
                SACS_H_SHIFT:
                begin
                    cnt_r <= halfTick ? 16'h0 : cnt_r + 16'h1;
                    if (halfTick)
                    begin
                        sclk_r <= ~sclk_r; // R13 R17
                        if (sclk_r)
                        begin
                            rx_r   <= rxNext; // R8
                            bits_r <= bits_r - 6'h1;
                            if (bits_r == 6'h1)
                            begin
                                state_r  <= SACS_H_QUIET;
                                result_r <= rxNext;
                                valid_r  <= 1'b1;
                            end
                        end
                    end
                end
                SACS_H_QUIET:
                begin
                    cnt_r <= cnt_r + 16'h1;
                    if (cnt_r >= 16'(QUIET_CYC))
                        state_r <= SACS_H_IDLE; // R10
                end
                default:
                    state_r <= SACS_H_IDLE;
            endcase
        end
    end

    assign link.convStart = start_r;
    assign link.serialClk = sclk_r;
    assign busy           = (state_r != SACS_H_IDLE);
    assign result         = result_r;
    assign resultValid    = valid_r;
endmodule : sacs_host

// [sim/sacs_link_props.sv]
// Checker for the serial link between converter sequencer and host.
// Assumes one clock domain and plain copies of the link signals.
module sacs_link_props #(
    parameter int RES_BITS = 14,
    parameter int CONV_CYC = 30
)(
    input wire logic clk,
    input wire logic srst,
    input wire logic convStart,
    input wire logic serialClk,
    input wire logic serialData,
    input wire logic serialDataEn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hiCnt_r;
    logic [7:0] fallCnt_r;
    logic       prevClk_r;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Count start-high cycles and serial clock falls within one readout.
    always_ff @(posedge clk)
    begin
        hiCnt_r   <= (srst || !convStart) ? 8'h00 : hiCnt_r + 8'h01;
        fallCnt_r <= (srst || !serialDataEn) ? 8'h00 : fallCnt_r + 8'(!serialClk && prevClk_r);
        prevClk_r <= serialClk;
    end
    AST_EN_AFTER_LOW: assert property ($rose(serialDataEn) |-> !convStart)
        else $error("Data enabled while start high.");
    AST_START_HOLDS: assert property ($rose(convStart) |-> convStart [*8])
        else $error("Start dropped too early.");
    AST_CONV_LEN: assert property ($fell(convStart) |-> hiCnt_r >= CONV_CYC)
        else $error("Start low before conversion end.");
    AST_CLK_QUIET_CONV: assert property (convStart |-> !serialClk)
        else $error("Serial clock runs during conversion.");
    AST_DATA_STABLE: assert property (serialClk && $past(serialClk) && serialDataEn |-> $stable(serialData))
        else $error("Data changed while serial clock high.");
    AST_QUIET_GAP: assert property ($rose(convStart) |-> !$past(serialClk))
        else $error("No quiet gap before start.");
    AST_BIT_COUNT: assert property (serialDataEn |-> fallCnt_r <= RES_BITS)
        else $error("Too many bits shifted.");
    AST_EN_ENDS: assert property ($rose(serialDataEn) |-> ##[1:300] !serialDataEn)
        else $error("Output enable never released.");
endmodule : sacs_link_props

// [sim/testbench.sv]
// Self-checking bench joining device and host ends over one link.
// Assumes the default counts of the shared parameter header.
`include "sacs_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic               startReq = 1'b0;
    logic signed [13:0] sampleIn = 14'sh0000;
    logic               tracking, converting, calibrating, busy, resultValid;
    logic [13:0]        result;
    int                 failures = 0;
    int                 checks_done = 0;
    int                 cycles = 0;
    logic [13:0]        codes [7] = '{14'h0000, 14'h0001, 14'h3fff, 14'h1fff, 14'h2000, 14'h2aaa, 14'h1555};
    sacs_link_if link ();
    sacs_device sacs_device_i (.clk(clk), .srst(srst), .link(link.device), .sampleIn(sampleIn),
        .tracking(tracking), .converting(converting), .calibrating(calibrating));
    sacs_host sacs_host_i (.clk(clk), .srst(srst), .link(link.host), .startReq(startReq),
        .busy(busy), .result(result), .resultValid(resultValid));
    sacs_link_props #(.RES_BITS(`SACS_RES_BITS), .CONV_CYC(`SACS_CONV_CYCLES)) sacs_link_props_i (
        .clk(clk), .srst(srst),
        .convStart(link.convStart), .serialClk(link.serialClk), .serialData(link.serialData),
        .serialDataEn(link.serialDataEn));
    // Free-running system clock and a cycle ceiling against hangs.
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            end_sim();
        end
    end
    // Compares one value and reports a mismatch at once.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Runs one conversion, disturbs the input once it is frozen, then reads back.
    task automatic convert(input logic [13:0] v);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        check("host idle", busy, 1'b0);
        @(posedge clk);
        #2 sampleIn = v;
        startReq = 1'b1;
        @(posedge clk);
        #2 startReq = 1'b0;
        n = 0;
        while (converting !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        #2 sampleIn = ~v;
        n = 0;
        while (converting === 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        check("conv length", n, `SACS_CONV_CYCLES);
        n = 0;
        while (link.serialDataEn !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        check("data enable", link.serialDataEn, 1'b1);
        check("tracking in readout", tracking, 1'b1);
        n = 0;
        while (resultValid !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        check("result valid", resultValid, 1'b1);
        check("result", result, v);
    endtask : convert
    // Prints counts and verdict, then stops.
    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // Main sequence: calibration, then conversions over boundary and alternating-bit codes.
    initial
    begin
        int n;
        repeat (8) @(posedge clk);
        #2 srst = 1'b0;
        check("calibrating", calibrating, 1'b1);
        n = 0;
        while (tracking !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        check("cal length", n, `SACS_CAL_CYCLES + 1);
        check("tracking", tracking, 1'b1);
        $display("test calibration done");
        foreach (codes[i])
            convert(codes[i]);
        $display("test codes done");
        end_sim();
    end
endmodule : testbench
